/* include/err_map_pkg.sv */
package err_map_pkg;
  // ****************************************************
  // Widths and field positions
  // ****************************************************
  localparam int CODE_W = 8;
  localparam int UNIT_W = 4;
  localparam int OUTCOME_LSB = 0;
  localparam int HEADER_BIT = 2;
  localparam int DATA_BIT = 3;
  localparam int CRC_BIT = 4;
  localparam int CTRL_PAR_BIT = 5;
  localparam int RUN_BIT = 6;
  localparam int PAR_BYTE_BIT = 7;
  localparam logic [1:0] OUTCOME_CORR = 2'h0;
  localparam logic [1:0] OUTCOME_UNCORR = 2'h1;
  localparam logic [1:0] OUTCOME_NONE = 2'h2;
  localparam logic [3:0] UNIT_UNKNOWN = 4'h0;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam int LOG_DEPTH = 32;
  localparam int LOG_AW = 5;

  typedef struct packed {
    logic test;
    logic [7:0] code;
  } log_entry_type;

  typedef struct packed {
    logic header;
    logic data;
    logic crc;
    logic ctrl_par;
    logic run;
    logic par_byte;
    logic [1:0] outcome;
  } sector_flags_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } rd_state_type;
endpackage

/* hdl/log_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module log_mem #(
  parameter int AW = 5,
  parameter int DW = 9
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic wr_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [DW-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Registered read data, no reset so it maps to block RAM
  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      if (wr_in) begin
        mem[waddr_in] <= wdata_in;
      end
      rdata_out <= mem[raddr_in];
    end
  end
endmodule
`default_nettype wire

/* hdl/disc_error_code_mapper.sv */
// Operation
// - An error raised while self-test is idle is classed as a drive error.
// - Each drive error whose servo code is in the table goes both to current status and to the fault log.
// - The same code raised during self-test is logged as a test error.
// - Logged entries are read back on request by the exerciser port.
// - Servo codes are translated by a fixed table before logging.
// - An error raised while self-test runs, however started, is a test error.
// - Test errors carry a replaceable unit code in status, not in the log.
`timescale 1ns/1ns
`default_nettype none
module disc_error_code_mapper
  import err_map_pkg::*;
#(
  parameter int DEPTH_AW = err_map_pkg::LOG_AW
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic SELF_TEST_IN,
  input wire logic ERR_VALID_IN,
  input wire logic [err_map_pkg::CODE_W-1:0] SERVO_CODE_IN,
  input wire logic [err_map_pkg::UNIT_W-1:0] UNIT_CODE_IN,
  input wire logic LOG_RD_REQ_IN,
  input wire logic [DEPTH_AW-1:0] LOG_RD_IDX_IN,
  input wire err_map_pkg::sector_flags_type SECTOR_IN,
  output logic STATUS_VALID_OUT,
  output err_map_pkg::log_entry_type STATUS_OUT,
  output logic [err_map_pkg::UNIT_W-1:0] STATUS_UNIT_OUT,
  output logic MAP_MISS_OUT,
  output logic [DEPTH_AW:0] LOG_COUNT_OUT,
  output logic LOG_RD_VALID_OUT,
  output err_map_pkg::log_entry_type LOG_RD_DATA_OUT,
  output logic [err_map_pkg::CODE_W-1:0] SECTOR_BYTE_OUT
);
  import err_map_pkg::*;

  // ****************************************************
  // Servo code translation
  // ****************************************************
  logic [7:0] mapped;
  logic map_hit;

  always_comb begin
    map_hit = 1'b1;
    case (SERVO_CODE_IN)
      8'h01: mapped = 8'hAC;
      8'h02: mapped = 8'h72;
      8'h03: mapped = 8'h73;
      8'h06: mapped = 8'h76;
      8'h07: mapped = 8'h78;
      8'h09: mapped = 8'hB9;
      8'h0A: mapped = 8'h79;
      8'h0B: mapped = 8'h7A;
      8'h0C: mapped = 8'h7B;
      8'h0E: mapped = 8'h7D;
      8'h10: mapped = 8'h7F;
      8'h13: mapped = 8'h80;
      8'h16: mapped = 8'hAD;
      8'h17: mapped = 8'h1C;
      8'h18: mapped = 8'h66;
      8'h19: mapped = 8'hBA;
      8'h1A: mapped = 8'hBB;
      8'h1B: mapped = 8'hBC;
      8'h1C: mapped = 8'hBD;
      default: begin
        mapped = CODE_RESET;
        map_hit = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // Classification and status
  // ****************************************************
  // Self-test level is same-clock logic, so sampled directly
  wire log_entry_type next_entry = '{test: SELF_TEST_IN, code: mapped};
  wire accept = CE_IN && ERR_VALID_IN && map_hit;
  wire [UNIT_W-1:0] next_unit = SELF_TEST_IN ? UNIT_CODE_IN : UNIT_UNKNOWN;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      STATUS_VALID_OUT <= 1'b0;
      STATUS_OUT <= '0;
      STATUS_UNIT_OUT <= UNIT_UNKNOWN;
      MAP_MISS_OUT <= 1'b0;
    end else if (CE_IN) begin
      MAP_MISS_OUT <= ERR_VALID_IN && !map_hit;
      if (accept) begin
        STATUS_VALID_OUT <= 1'b1;
        STATUS_OUT <= next_entry;
        STATUS_UNIT_OUT <= next_unit;
      end
    end
  end

  // ****************************************************
  // Fault log, wraps when full and keeps newest entries
  // ****************************************************
  logic [DEPTH_AW-1:0] wr_ptr;
  logic [DEPTH_AW:0] next_count;
  wire [DEPTH_AW:0] log_max = (DEPTH_AW+1)'(1 << DEPTH_AW);
  assign next_count = (LOG_COUNT_OUT == log_max) ? LOG_COUNT_OUT
                                                  : LOG_COUNT_OUT + 1'b1;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wr_ptr <= '0;
      LOG_COUNT_OUT <= '0;
    end else if (accept) begin
      wr_ptr <= wr_ptr + 1'b1;
      LOG_COUNT_OUT <= next_count;
    end
  end

  // Unit code deliberately not stored in the log
  log_entry_type rd_word;
  log_mem #(.AW(DEPTH_AW), .DW($bits(log_entry_type))) log_mem_inst (
    .clk_in(CORE_CLK_IN),
    .ce_in(CE_IN),
    .wr_in(accept),
    .waddr_in(wr_ptr),
    .wdata_in(next_entry),
    .raddr_in(LOG_RD_IDX_IN),
    .rdata_out(rd_word)
  );

  // ****************************************************
  // Exerciser read port: request, one wait, then data
  // ****************************************************
  rd_state_type state;
  rd_state_type next_state;

  always_comb begin
    case (state)
      ST_IDLE: next_state = LOG_RD_REQ_IN ? ST_READ : ST_IDLE;
      ST_READ: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= ST_IDLE;
      LOG_RD_VALID_OUT <= 1'b0;
      LOG_RD_DATA_OUT <= '0;
    end else if (CE_IN) begin
      state <= next_state;
      LOG_RD_VALID_OUT <= (state == ST_READ);
      if (state == ST_READ) begin
        LOG_RD_DATA_OUT <= rd_word;
      end
    end
  end

  // ****************************************************
  // Sector error code byte
  // ****************************************************
  logic [7:0] next_sector;
  always_comb begin
    next_sector = CODE_RESET;
    next_sector[OUTCOME_LSB +: 2] = SECTOR_IN.outcome;
    next_sector[HEADER_BIT] = SECTOR_IN.header;
    next_sector[DATA_BIT] = SECTOR_IN.data;
    next_sector[CRC_BIT] = SECTOR_IN.crc;
    next_sector[CTRL_PAR_BIT] = SECTOR_IN.ctrl_par;
    next_sector[RUN_BIT] = SECTOR_IN.run;
    next_sector[PAR_BYTE_BIT] = SECTOR_IN.par_byte;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SECTOR_BYTE_OUT <= {6'h00, OUTCOME_NONE};
    end else if (CE_IN) begin
      SECTOR_BYTE_OUT <= next_sector;
    end
  end

  // ****************************************************
  // Checks
  // ****************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence s_err_taken;
    CE_IN && ERR_VALID_IN && map_hit;
  endsequence
  sequence s_rd_req;
    CE_IN && LOG_RD_REQ_IN && state == ST_IDLE;
  endsequence

  a_drive_class: assert property (s_err_taken and !SELF_TEST_IN |=>
    STATUS_VALID_OUT && !STATUS_OUT.test)
    else $error("drive error misclassified");
  a_test_class: assert property (s_err_taken and SELF_TEST_IN |=>
    STATUS_OUT.test && STATUS_OUT.code == $past(mapped))
    else $error("test error misclassified");
  a_selftest_unit: assert property (s_err_taken and SELF_TEST_IN |=>
    STATUS_UNIT_OUT == $past(UNIT_CODE_IN))
    else $error("unit code lost");
  a_unit_drive: assert property (s_err_taken and !SELF_TEST_IN |=>
    STATUS_UNIT_OUT == UNIT_UNKNOWN)
    else $error("drive error carries unit code");
  a_log_count: assert property (s_err_taken and LOG_COUNT_OUT == '0 |=>
    LOG_COUNT_OUT == 1 && wr_ptr == $past(wr_ptr) + 1'b1)
    else $error("log not written");
  a_map_known: assert property (CE_IN && ERR_VALID_IN &&
    SERVO_CODE_IN == 8'h09 |=> STATUS_OUT.code == 8'hB9 && !MAP_MISS_OUT)
    else $error("servo code mapping wrong");
  a_map_miss: assert property (CE_IN && ERR_VALID_IN && !map_hit |=>
    MAP_MISS_OUT && $stable(LOG_COUNT_OUT))
    else $error("unmapped code logged");
  a_read_timing: assert property (s_rd_req ##1 CE_IN |=>
    LOG_RD_VALID_OUT ##1 !LOG_RD_VALID_OUT || !CE_IN)
    else $error("read answer timing wrong");
  a_sector_byte: assert property (CE_IN |=>
    SECTOR_BYTE_OUT[1:0] == $past(SECTOR_IN.outcome) &&
    SECTOR_BYTE_OUT[7] == $past(SECTOR_IN.par_byte))
    else $error("sector byte wrong");
endmodule
`default_nettype wire

/* verif/servo_model.sv */
`timescale 1ns/1ns
`default_nettype none
module servo_model
  import err_map_pkg::*;
(
  input wire logic clk_in,
  output logic err_valid_out,
  output logic [err_map_pkg::CODE_W-1:0] code_out
);
  // ****************************************************
  // One-cycle report, then the bus shows junk
  // ****************************************************
  initial begin
    err_valid_out = 1'b0;
    code_out = 8'h00;
  end
  // Inverted code after release so stale data never looks valid
  task automatic send(input logic [CODE_W-1:0] code);
    @(negedge clk_in);
    err_valid_out = 1'b1;
    code_out = code;
    @(negedge clk_in);
    err_valid_out = 1'b0;
    code_out = ~code;
  endtask
endmodule
`default_nettype wire

/* verif/disc_error_code_mapper_test.sv */
`timescale 1ns/1ns
`default_nettype none
module disc_error_code_mapper_test;
  import err_map_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic self_test = 1'b0;
  logic [3:0] unit = 4'h0;
  logic rd_req = 1'b0;
  logic [4:0] rd_idx = 5'h00;
  sector_flags_type sector = '0;
  logic err_valid, st_valid, miss, rd_valid;
  logic [7:0] servo_code, sec_byte;
  log_entry_type status, rd_data;
  logic [3:0] st_unit;
  logic [5:0] count;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  localparam logic [7:0] SRV [19] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07,
    8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0E, 8'h10, 8'h13, 8'h16, 8'h17, 8'h18,
    8'h19, 8'h1A, 8'h1B, 8'h1C};
  localparam logic [7:0] LOGC [19] = '{8'hAC, 8'h72, 8'h73, 8'h76, 8'h78,
    8'hB9, 8'h79, 8'h7A, 8'h7B, 8'h7D, 8'h7F, 8'h80, 8'hAD, 8'h1C, 8'h66,
    8'hBA, 8'hBB, 8'hBC, 8'hBD};
  always #4 clk = ~clk;
  servo_model servo_model_inst (.clk_in(clk), .err_valid_out(err_valid),
    .code_out(servo_code));
  disc_error_code_mapper disc_error_code_mapper_inst (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
    .SELF_TEST_IN(self_test), .ERR_VALID_IN(err_valid),
    .SERVO_CODE_IN(servo_code), .UNIT_CODE_IN(unit),
    .LOG_RD_REQ_IN(rd_req), .LOG_RD_IDX_IN(rd_idx), .SECTOR_IN(sector),
    .STATUS_VALID_OUT(st_valid), .STATUS_OUT(status),
    .STATUS_UNIT_OUT(st_unit), .MAP_MISS_OUT(miss),
    .LOG_COUNT_OUT(count), .LOG_RD_VALID_OUT(rd_valid),
    .LOG_RD_DATA_OUT(rd_data), .SECTOR_BYTE_OUT(sec_byte));
  // ****************************************************
  // Compare and verdict
  // ****************************************************
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude();
    end
  end
  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic test_reset;
    chk(9'(st_valid), 9'h000);
    chk(9'(sec_byte), 9'h002);
    chk(9'(count), 9'h000);
    chk(status, 9'h000);
    chk(9'(st_unit), 9'h000);
    chk(9'(miss), 9'h000);
    chk(9'(rd_valid), 9'h000);
    chk(rd_data, 9'h000);
  endtask
  // Alternate self-test between drive and test errors
  task automatic test_table;
    for (int i = 0; i < 19; i++) begin
      self_test = i[0];
      unit = i[3:0];
      servo_model_inst.send(SRV[i]);
      chk(status, {i[0], LOGC[i]});
      chk(9'(st_unit), i[0] ? 9'(i[3:0]) : 9'h000);
      chk(9'(count), 9'(i + 1));
      chk(9'(st_valid), 9'h001);
    end
  endtask
  task automatic test_miss;
    servo_model_inst.send(8'h04);
    chk(9'(miss), 9'h001);
    chk(9'(count), 9'h013);
    chk(status, {1'b0, LOGC[18]});
    @(negedge clk);
    chk(9'(miss), 9'h000);
  endtask
  // Past 32 entries: count saturates, oldest slot is overwritten
  task automatic test_wrap;
    self_test = 1'b0;
    for (int j = 0; j < 14; j++) begin
      servo_model_inst.send(SRV[j]);
      chk(status, {1'b0, LOGC[j]});
      chk(9'(count), 9'((j < 13) ? 20 + j : 32));
    end
    @(negedge clk);
    rd_req = 1'b1;
    rd_idx = 5'h00;
    @(negedge clk);
    rd_req = 1'b0;
    @(negedge clk);
    chk(9'(rd_valid), 9'h001);
    chk(rd_data, {1'b0, LOGC[13]});
  endtask
  // Enable low must freeze log, status and sector byte
  task automatic test_freeze;
    ce = 1'b0;
    sector = sector_flags_type'(8'hFF);
    servo_model_inst.send(SRV[0]);
    chk(9'(count), 9'h020);
    chk(status, {1'b0, LOGC[13]});
    chk(9'(sec_byte), 9'h000);
    ce = 1'b1;
    @(negedge clk);
    chk(9'(sec_byte), 9'h0FF);
  endtask
  task automatic test_read;
    int w;
    for (int k = 0; k < 19; k++) begin
      @(negedge clk);
      rd_req = 1'b1;
      rd_idx = k[4:0];
      @(negedge clk);
      rd_req = 1'b0;
      for (w = 0; w < 4 && rd_valid !== 1'b1; w++)
        @(negedge clk);
      chk(9'(rd_valid), 9'h001);
      chk(rd_data, {k[0], LOGC[k]});
    end
  endtask
  task automatic test_sector;
    sector_flags_type s;
    for (int k = 0; k < 9; k++) begin
      s = sector_flags_type'(8'h01 << k);
      sector = s;
      @(negedge clk);
      chk(9'(sec_byte), 9'({s.par_byte, s.run, s.ctrl_par, s.crc,
        s.data, s.header, s.outcome}));
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    test_reset();
    test_table();
    test_miss();
    test_read();
    test_wrap();
    test_sector();
    test_freeze();
    conclude();
  end
endmodule
`default_nettype wire
